// >>> hw/lbs_core.sv
// module: lin break and sync detector with avalon-mm registers
`timescale 1ns/1ns
module lbs_core (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // avalon-mm slave
  input wire logic [lbs_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // transceiver side
  input wire logic lin_rx_in,
  output logic lin_tx_out,
  // uart side
  input wire logic uart_tx_in,
  output logic uart_rx_out,
  // test mode gpio pins
  input wire logic gpio_tx_in,
  output logic gpio_rx_out,
  // event pulses
  output logic start_irq_out,
  output logic stop_irq_out,
  output logic brk_cmp_irq_out,
  output logic brk_err_irq_out
);

  logic [15:0] ctrl0;
  logic [7:0] edge_cfg;
  logic [lbs_pkg::BRK_W-1:0] brk_cmp;
  logic [lbs_pkg::BRK_W-1:0] brk_timer;
  logic [lbs_pkg::CNT_W-1:0] fall_cnt;
  logic [lbs_pkg::CNT_W-1:0] rise_cnt;
  logic [lbs_pkg::ST_FLAGS-1:0] flags;
  logic [lbs_pkg::SRST_W-1:0] srst_cnt;
  lbs_pkg::lbs_state_e state;
  lbs_pkg::lbs_state_e next_state;
  logic rx_s1, rx_s2, rx_d;
  logic gtx_s1, gtx_s2;
  logic done_q;
  logic tick;
  logic cmp_seen, err_seen;
  logic soft_rst, req, wr_take;
  logic fall, rise, active, in_cnt;
  logic stop_edge, stop_hit, start_hit, cmp_hit, err_hit;
  logic [lbs_pkg::CNT_W-1:0] next_fall, next_rise, stop_num, start_num;
  logic [31:0] rd_val, wr_val, w1c;

  // byte-lane merge of write data into the current value
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // edge counter step, saturating so a long frame cannot wrap back
  function automatic logic [lbs_pkg::CNT_W-1:0] cnt_step(
    input logic [lbs_pkg::CNT_W-1:0] c, input logic inc);
    logic [lbs_pkg::CNT_W-1:0] r;
    r = c;
    if (inc && (c != '1))
    begin
      r = c + 1'b1;
    end
    return r;
  endfunction : cnt_step

  // reference tick generator, held while no frame is timed
  lbs_tick_gen u_tick (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clear_in(!active),
    .tick_out(tick)
  );

  // pin synchronisers; first stages feed only the second
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_s1 <= lbs_pkg::LIN_IDLE;
      rx_s2 <= lbs_pkg::LIN_IDLE;
      rx_d <= lbs_pkg::LIN_IDLE;
      gtx_s1 <= lbs_pkg::LIN_IDLE;
      gtx_s2 <= lbs_pkg::LIN_IDLE;
    end
    else
    begin
      rx_s1 <= lin_rx_in;
      rx_s2 <= rx_s1;
      rx_d <= rx_s2;
      gtx_s1 <= gpio_tx_in;
      gtx_s2 <= gtx_s1;
    end
  end

  // decode of bus, edges and frame events
  always_comb
  begin
    soft_rst = ctrl0[lbs_pkg::CTL_SRST];
    req = avs_read_in | avs_write_in;
    avs_waitrequest_out = req & !done_q;
    wr_take = req & done_q & avs_write_in;
    fall = rx_d & !rx_s2;
    rise = !rx_d & rx_s2;
    active = (state == lbs_pkg::ST_BREAK) || (state == lbs_pkg::ST_SYNC);
    // break fall is edge one, so counts match the frame's edge numbers
    in_cnt = ((state == lbs_pkg::ST_IDLE) && ctrl0[lbs_pkg::CTL_EN]) ||
             active;
    next_fall = cnt_step(fall_cnt, fall & in_cnt);
    next_rise = cnt_step(rise_cnt, rise & (state == lbs_pkg::ST_SYNC));
    stop_num = edge_cfg[lbs_pkg::CFG_STOP_LSB +: lbs_pkg::CNT_W];
    start_num = edge_cfg[lbs_pkg::CFG_START_LSB +: lbs_pkg::CNT_W];
    if (ctrl0[lbs_pkg::CTL_STOP_RISE])
    begin
      stop_edge = rise && (state == lbs_pkg::ST_SYNC) &&
                  (next_rise == stop_num);
    end
    else
    begin
      stop_edge = fall && in_cnt && (next_fall == stop_num);
    end
    stop_hit = stop_edge && (stop_num != '0) &&
               !ctrl0[lbs_pkg::CTL_CNT_CLR];
    start_hit = fall && in_cnt && (next_fall == start_num) &&
                (start_num != '0) && !ctrl0[lbs_pkg::CTL_CNT_CLR];
    cmp_hit = active && !cmp_seen && (brk_timer > brk_cmp);
    err_hit = active && !err_seen && (brk_timer == '1);
  end

  // frame sequencer; enable low parks it in idle
  always_comb
  begin
    next_state = state;
    case (state)
      lbs_pkg::ST_IDLE:
      begin
        if (stop_hit)
        begin
          next_state = lbs_pkg::ST_DONE;
        end
        else if (fall)
        begin
          next_state = lbs_pkg::ST_BREAK;
        end
      end
      lbs_pkg::ST_BREAK:
      begin
        if (stop_hit)
        begin
          next_state = lbs_pkg::ST_DONE;
        end
        else if (fall)
        begin
          next_state = lbs_pkg::ST_SYNC;
        end
      end
      lbs_pkg::ST_SYNC:
      begin
        if (stop_hit)
        begin
          next_state = lbs_pkg::ST_DONE;
        end
      end
      lbs_pkg::ST_DONE:
      begin
        next_state = lbs_pkg::ST_DONE;
      end
      default:
      begin
        next_state = lbs_pkg::ST_IDLE;
      end
    endcase
    if (!ctrl0[lbs_pkg::CTL_EN])
    begin
      next_state = lbs_pkg::ST_IDLE;
    end
  end

  // register read mux; unmapped words read as zero
  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (avs_address_in)
      lbs_pkg::IDX_CTRL0: rd_val[15:0] = ctrl0;
      lbs_pkg::IDX_EDGE_CFG: rd_val[7:0] = edge_cfg;
      lbs_pkg::IDX_BRK_CMP: rd_val[lbs_pkg::BRK_W-1:0] = brk_cmp;
      lbs_pkg::IDX_EDGE_CNT: rd_val[7:0] = {rise_cnt, fall_cnt};
      lbs_pkg::IDX_BRK_TMR: rd_val[lbs_pkg::BRK_W-1:0] = brk_timer;
      lbs_pkg::IDX_STATUS:
      begin
        rd_val[lbs_pkg::ST_FLAGS-1:0] = flags;
        rd_val[lbs_pkg::ST_RST_DONE] = !soft_rst;
      end
      default: rd_val = 32'h0000_0000;
    endcase
    wr_val = be_merge(rd_val, avs_writedata_in, avs_byteenable_in);
    w1c = be_merge(32'h0000_0000, avs_writedata_in, avs_byteenable_in);
  end

  // bus answer: one wait cycle, read data captured then
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      done_q <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
    end
    else
    begin
      done_q <= req & !done_q;
      if (avs_read_in && !done_q)
      begin
        avs_readdata_out <= rd_val;
      end
    end
  end

  // control register with self clearing unit reset
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl0 <= lbs_pkg::CTRL0_RST;
      srst_cnt <= '0;
    end
    else if (soft_rst)
    begin
      // writes are dropped until the reset has run out
      if (srst_cnt == lbs_pkg::SRST_LAST)
      begin
        ctrl0 <= lbs_pkg::CTRL0_RST;
        srst_cnt <= '0;
      end
      else
      begin
        srst_cnt <= srst_cnt + 1'b1;
      end
    end
    else if (wr_take && (avs_address_in == lbs_pkg::IDX_CTRL0))
    begin
      if (wr_val[lbs_pkg::CTL_SRST])
      begin
        ctrl0 <= lbs_pkg::CTRL0_SRST_VAL;
      end
      else
      begin
        ctrl0 <= wr_val[15:0] & lbs_pkg::CTRL0_WMASK;
      end
    end
  end

  // edge config and break compare value
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      edge_cfg <= lbs_pkg::EDGE_CFG_RST;
      brk_cmp <= lbs_pkg::BRK_CMP_RST;
    end
    else if (soft_rst)
    begin
      edge_cfg <= lbs_pkg::EDGE_CFG_RST;
      brk_cmp <= lbs_pkg::BRK_CMP_RST;
    end
    else if (wr_take && (avs_address_in == lbs_pkg::IDX_EDGE_CFG))
    begin
      edge_cfg <= wr_val[7:0];
    end
    else if (wr_take && (avs_address_in == lbs_pkg::IDX_BRK_CMP))
    begin
      brk_cmp <= wr_val[lbs_pkg::BRK_W-1:0];
    end
  end

  // sequencer state
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= lbs_pkg::ST_IDLE;
    end
    else if (soft_rst)
    begin
      state <= lbs_pkg::ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // edge counters, held at zero by the clear bit and in idle
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      fall_cnt <= '0;
      rise_cnt <= '0;
    end
    else if (soft_rst || ctrl0[lbs_pkg::CTL_CNT_CLR] ||
             (next_state == lbs_pkg::ST_IDLE))
    begin
      fall_cnt <= '0;
      rise_cnt <= '0;
    end
    else if (state != lbs_pkg::ST_DONE)
    begin
      fall_cnt <= next_fall;
      rise_cnt <= next_rise;
    end
  end

  // break timer in reference periods, saturating at all ones
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      brk_timer <= '0;
      cmp_seen <= 1'b0;
      err_seen <= 1'b0;
    end
    else if (soft_rst || (state == lbs_pkg::ST_IDLE))
    begin
      brk_timer <= '0;
      cmp_seen <= 1'b0;
      err_seen <= 1'b0;
    end
    else
    begin
      if (active && tick && (brk_timer != '1))
      begin
        brk_timer <= brk_timer + 1'b1;
      end
      cmp_seen <= cmp_seen | cmp_hit;
      err_seen <= err_seen | err_hit;
    end
  end

  // sticky status, write one clears, a new event wins over the clear
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      flags <= '0;
    end
    else if (soft_rst)
    begin
      flags <= '0;
    end
    else
    begin
      flags <= (flags & ~((wr_take &&
                (avs_address_in == lbs_pkg::IDX_STATUS)) ?
                w1c[lbs_pkg::ST_FLAGS-1:0] : 4'h0)) |
               {err_hit, cmp_hit, stop_hit, start_hit};
    end
  end

  // interrupt pulses gated by their enable and disable bits
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      start_irq_out <= 1'b0;
      stop_irq_out <= 1'b0;
      brk_cmp_irq_out <= 1'b0;
      brk_err_irq_out <= 1'b0;
    end
    else
    begin
      start_irq_out <= start_hit & ctrl0[lbs_pkg::CTL_START_IE];
      stop_irq_out <= stop_hit & ctrl0[lbs_pkg::CTL_STOP_IE];
      brk_cmp_irq_out <= cmp_hit & !ctrl0[lbs_pkg::CTL_BRK_CMP_DIS];
      brk_err_irq_out <= err_hit & !ctrl0[lbs_pkg::CTL_BRK_ERR_DIS];
    end
  end

  // pin routing; uart rx stays gated until the frame head is seen
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      lin_tx_out <= lbs_pkg::LIN_IDLE;
      uart_rx_out <= lbs_pkg::LIN_IDLE;
      gpio_rx_out <= lbs_pkg::LIN_IDLE;
    end
    else
    begin
      lin_tx_out <= ctrl0[lbs_pkg::CTL_TEST] ? gtx_s2 : uart_tx_in;
      gpio_rx_out <= ctrl0[lbs_pkg::CTL_TEST] ? rx_s2 : lbs_pkg::LIN_IDLE;
      if (ctrl0[lbs_pkg::CTL_TEST] ||
          (ctrl0[lbs_pkg::CTL_GATE] && (state != lbs_pkg::ST_DONE)))
      begin
        uart_rx_out <= lbs_pkg::LIN_IDLE;
      end
      else
      begin
        uart_rx_out <= rx_s2;
      end
    end
  end

  // checks
  default clocking a_cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  logic [lbs_pkg::SRST_W-1:0] a_len;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      a_len <= '0;
    end
    else
    begin
      a_len <= soft_rst ? a_len + 1'b1 : '0;
    end
  end

  property p_cmp_dis;
    brk_cmp_irq_out |-> $past(!ctrl0[11] && brk_timer > brk_cmp);
  endproperty
  a_cmp_dis: assert property (p_cmp_dis) else $error("cmp irq masked");
  property p_err_dis;
    brk_err_irq_out |-> $past(!ctrl0[10] && brk_timer == '1);
  endproperty
  a_err_dis: assert property (p_err_dis) else $error("err irq masked");
  property p_route;
    ctrl0[9] ##1 ctrl0[9] |=> lin_tx_out == $past(gtx_s2) && uart_rx_out;
  endproperty
  a_route: assert property (p_route) else $error("test route wrong");
  property p_gate;
    (ctrl0[8] && state != lbs_pkg::ST_DONE) |=> uart_rx_out;
  endproperty
  a_gate: assert property (p_gate) else $error("uart rx not gated");
  property p_stop_edge;
    stop_irq_out |-> $past(ctrl0[7] ? rise : fall);
  endproperty
  a_stop_edge: assert property (p_stop_edge) else $error("stop edge");
  property p_stop_ie;
    stop_irq_out |-> $past(ctrl0[4]) ##1 state == lbs_pkg::ST_DONE;
  endproperty
  a_stop_ie: assert property (p_stop_ie) else $error("stop irq");
  property p_start_ie;
    start_irq_out |-> $past(ctrl0[3] && next_fall == start_num);
  endproperty
  a_start_ie: assert property (p_start_ie) else $error("start irq");
  property p_enable;
    !ctrl0[lbs_pkg::CTL_EN] ##1 !ctrl0[lbs_pkg::CTL_EN] |=>
      state == lbs_pkg::ST_IDLE && !stop_irq_out;
  endproperty
  a_enable: assert property (p_enable) else $error("not idle");
  property p_cnt_clr;
    ctrl0[1] |=> fall_cnt == '0 && rise_cnt == '0;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("cnt not clear");
  property p_srst_len;
    $fell(ctrl0[0]) |-> $past(a_len) == lbs_pkg::SRST_LAST;
  endproperty
  a_srst_len: assert property (p_srst_len) else $error("srst len");
  property p_done;
    (avs_read_in && !done_q && soft_rst &&
     avs_address_in == lbs_pkg::IDX_STATUS) |=>
      !avs_readdata_out[lbs_pkg::ST_RST_DONE];
  endproperty
  a_done: assert property (p_done) else $error("done too early");

  c_stop: cover property (stop_irq_out);
  c_start: cover property (start_irq_out);
  c_cmp: cover property (brk_cmp_irq_out);
  c_srst: cover property ($fell(ctrl0[0]));

endmodule : lbs_core

// >>> hw/lbs_tick_gen.sv
// module: 131 khz reference tick from the core clock
`timescale 1ns/1ns
module lbs_tick_gen (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control and tick
  input wire logic clear_in,
  output logic tick_out
);

  logic [lbs_pkg::TICK_W-1:0] div_cnt;

  // clear realigns the phase to the first falling edge of the frame
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      div_cnt <= '0;
      tick_out <= 1'b0;
    end
    else if (clear_in)
    begin
      div_cnt <= '0;
      tick_out <= 1'b0;
    end
    else if (div_cnt == lbs_pkg::TICK_LAST)
    begin
      div_cnt <= '0;
      tick_out <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 1'b1;
      tick_out <= 1'b0;
    end
  end

endmodule : lbs_tick_gen

// >>> inc/lbs_pkg.sv
// package: constants and types of the lin break and sync detector
// Overview of operation
// - ctrl bit 11 set masks break compare irq
// - ctrl bit 10 set masks break error irq
// - ctrl bit 9 swaps uart for gpio pins
// - ctrl bit 8 holds uart rx high until the stop condition
// - ctrl bit 7 picks stop edge polarity
// - ctrl bit 4 enables stop interrupt
// - ctrl bit 3 enables start interrupt
// - ctrl bit 2 is master enable
// - ctrl bit 1 holds edge counters cleared
// - ctrl bit 0 resets unit, clears after 15us
// - status bit 0x20 shows reset completed
// - break timer counts 131 khz periods
// - first fall starts timer; exceeding compare interrupts
// - first fall is edge one of the count; rises count from the next fall
// - configured edge count gives stop condition
package lbs_pkg;

  // timing
  localparam int CLK_KHZ = 125000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int REF_KHZ = 131;
  localparam int TICK_DIV = CLK_KHZ / REF_KHZ;
  localparam int TICK_W = 10;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);
  localparam int SRST_NS = 15000;
  localparam int SRST_CYC = (SRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SRST_W = 11;
  localparam logic [SRST_W-1:0] SRST_LAST = SRST_W'(SRST_CYC - 1);

  // system address of the control register, word indices on the bus
  localparam logic [31:0] CTRL0_SYS_ADDR = 32'hffff0784;
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] IDX_CTRL0 = 3'h0;
  localparam logic [ADDR_W-1:0] IDX_EDGE_CFG = 3'h1;
  localparam logic [ADDR_W-1:0] IDX_BRK_CMP = 3'h2;
  localparam logic [ADDR_W-1:0] IDX_EDGE_CNT = 3'h3;
  localparam logic [ADDR_W-1:0] IDX_BRK_TMR = 3'h4;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 3'h5;

  // control register fields
  localparam int CTL_BRK_CMP_DIS = 11;
  localparam int CTL_BRK_ERR_DIS = 10;
  localparam int CTL_TEST = 9;
  localparam int CTL_GATE = 8;
  localparam int CTL_STOP_RISE = 7;
  localparam int CTL_STOP_IE = 4;
  localparam int CTL_START_IE = 3;
  localparam int CTL_EN = 2;
  localparam int CTL_CNT_CLR = 1;
  localparam int CTL_SRST = 0;
  localparam logic [15:0] CTRL0_RST = 16'h0000;
  localparam logic [15:0] CTRL0_WMASK = 16'h0f9f;
  localparam logic [15:0] CTRL0_SRST_VAL = 16'h0001;

  // edge config fields and other widths
  localparam int CNT_W = 4;
  localparam int CFG_STOP_LSB = 4;
  localparam int CFG_START_LSB = 0;
  localparam logic [7:0] EDGE_CFG_RST = 8'h00;
  localparam int BRK_W = 12;
  localparam logic [BRK_W-1:0] BRK_CMP_RST = 12'h000;

  // status bits
  localparam int ST_START = 0;
  localparam int ST_STOP = 1;
  localparam int ST_BRK_CMP = 2;
  localparam int ST_BRK_ERR = 3;
  localparam int ST_FLAGS = 4;
  localparam int ST_RST_DONE = 5;

  // recessive bus level
  localparam logic LIN_IDLE = 1'b1;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_BREAK = 4'b0010,
    ST_SYNC  = 4'b0100,
    ST_DONE  = 4'b1000
  } lbs_state_e;

endpackage : lbs_pkg

// >>> verif/lbs_lin_model.sv
// lin bus model: remote node sending break, sync byte and one id byte
`timescale 1ns/1ns
module lbs_lin_model #(
  parameter int BIT_CYC = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // frame request
  input wire logic go_in,
  input wire logic [15:0] brk_cyc_in,
  output logic busy_out,
  // transceiver pins
  input wire logic lin_tx_in,
  output logic lin_rx_out
);
  // sync 0x55 then id 0x00, each framed, sent lsb first
  localparam logic [19:0] FRAME = {1'b1, 8'h00, 1'b0, 1'b1, 8'h55, 1'b0};
  logic [1:0] phase;
  logic [15:0] cnt;
  logic [4:0] bit_idx;
  logic drv;

  // frame sequencer; one bit time between break and sync byte
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase <= 2'h0;
      cnt <= 16'h0000;
      bit_idx <= 5'h00;
      drv <= 1'b1;
    end
    else if (phase == 2'h0)
    begin
      if (go_in)
      begin
        phase <= 2'h1;
        cnt <= brk_cyc_in;
        drv <= 1'b0;
      end
    end
    else if (cnt != 16'h0001)
      cnt <= cnt - 16'h0001;
    else if (phase == 2'h1)
    begin
      phase <= 2'h2;
      cnt <= 16'(BIT_CYC);
      drv <= 1'b1;
    end
    else if (phase == 2'h2)
    begin
      phase <= 2'h3;
      cnt <= 16'(BIT_CYC);
      bit_idx <= 5'h00;
      drv <= FRAME[0];
    end
    else if (bit_idx == 5'h13)
    begin
      phase <= 2'h0;
      drv <= 1'b1;
    end
    else
    begin
      bit_idx <= bit_idx + 5'h01;
      drv <= FRAME[bit_idx + 5'h01];
      cnt <= 16'(BIT_CYC);
    end
  end

  // wired-and bus with pull-up: own transmitter echoes back
  assign lin_rx_out = drv & lin_tx_in;
  assign busy_out = (phase != 2'h0);
endmodule : lbs_lin_model

// >>> verif/testbench.sv
// self-checking bench: register access, test mode and lin frames
`timescale 1ns/1ns
module testbench;
  logic clk_in, rst_in, rd, wr, wait_w, lin_rx, lin_tx, uart_tx, uart_rx;
  logic gpio_tx, gpio_rx, start_p, stop_p, cmp_p, err_p, go, busy, lin_q;
  logic [lbs_pkg::ADDR_W-1:0] adr;
  logic [31:0] wdat, rdat, v;
  logic [15:0] brk;
  int n_fail = 0, checked = 0, cyc = 0, n_start = 0, n_stop = 0, n_cmp = 0;
  int falls = 0, rises = 0, s_fall = 0, p_fall = 0, p_rise = 0, n_err = 0;
  int lo_pre = 0, s0_mark = 0, t0;
  // ctrl, cfg, cmp, break, start, stop, brk cmp, fall@start, edge@stop, low
  localparam int FT [6][10] = '{
    '{'h011c, 'h62, 2, 4000, 1, 1, 1, 2, 6, 0},
    '{'h0804, 'h62, 2, 4000, 0, 0, 0, 0, 0, 1},
    '{'h009c, 'h31, 2, 4000, 1, 1, 1, 1, 4, 1},
    '{'h011e, 'h62, 'hfff, 4000, 0, 0, 0, 0, 0, 0},
    '{'h0118, 'h62, 2, 4000, 0, 0, 0, 0, 0, 0},
    '{'h0014, 'h62, 2, 1500, 0, 1, 0, 0, 6, 1}};

  lbs_core lbs_core_i (.clk_in(clk_in), .rst_in(rst_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdat), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_w),
    .lin_rx_in(lin_rx), .lin_tx_out(lin_tx), .uart_tx_in(uart_tx),
    .uart_rx_out(uart_rx), .gpio_tx_in(gpio_tx), .gpio_rx_out(gpio_rx),
    .start_irq_out(start_p), .stop_irq_out(stop_p),
    .brk_cmp_irq_out(cmp_p), .brk_err_irq_out(err_p));
  lbs_lin_model lbs_lin_model_i (.clk_in(clk_in), .rst_in(rst_in),
    .go_in(go), .brk_cyc_in(brk), .busy_out(busy), .lin_tx_in(lin_tx),
    .lin_rx_out(lin_rx));

  // 125 mhz clock
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // event and bus-edge monitor plus hang guard
  always @(posedge clk_in)
  begin
    cyc++;
    if (lin_q === 1'b1 && lin_rx === 1'b0) falls++;
    if (lin_q === 1'b0 && lin_rx === 1'b1) rises++;
    lin_q = lin_rx;
    if (start_p === 1'b1)
    begin
      n_start++;
      s_fall = falls;
    end
    if (stop_p === 1'b1)
    begin
      n_stop++;
      p_fall = falls;
      p_rise = rises;
    end
    if (cmp_p === 1'b1) n_cmp++;
    if (err_p === 1'b1) n_err++;
    if (uart_rx === 1'b0 && n_stop == s0_mark) lo_pre++;
    if (cyc == 60000)
    begin
      n_fail++;
      complete_run();
    end
  end

  task complete_run;
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // avalon write: held until waitrequest is sampled low
  task bus_wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_in);
    adr <= a;
    wdat <= d;
    wr <= 1'b1;
    do @(posedge clk_in); while (wait_w !== 1'b0);
    wr <= 1'b0;
  endtask : bus_wr

  // avalon read: data taken at the edge that sees waitrequest low
  task bus_rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk_in);
    adr <= a;
    rd <= 1'b1;
    do @(posedge clk_in); while (wait_w !== 1'b0);
    d = rdat;
    rd <= 1'b0;
  endtask : bus_rd

  // one frame from the table, then event counts and edge positions
  task run_frame(input int k);
    int a0, b0, c0, f0, r0, l0;
    s0_mark = n_stop;
    bus_wr(lbs_pkg::IDX_CTRL0, 32'h0);
    bus_wr(lbs_pkg::IDX_STATUS, 32'hf);
    bus_wr(lbs_pkg::IDX_EDGE_CFG, 32'(FT[k][1]));
    bus_wr(lbs_pkg::IDX_BRK_CMP, 32'(FT[k][2]));
    bus_wr(lbs_pkg::IDX_CTRL0, 32'(FT[k][0]));
    a0 = n_start;
    b0 = n_stop;
    c0 = n_cmp;
    f0 = falls;
    r0 = rises;
    l0 = lo_pre;
    brk <= 16'(FT[k][3]);
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    @(posedge clk_in);
    while (busy === 1'b1) @(posedge clk_in);
    repeat (40) @(posedge clk_in);
    chk("start count", 32'(n_start - a0), 32'(FT[k][4]));
    chk("stop count", 32'(n_stop - b0), 32'(FT[k][5]));
    chk("brk cmp count", 32'(n_cmp - c0), 32'(FT[k][6]));
    if (FT[k][7] != 0)
      chk("falls at start", 32'(s_fall - f0), 32'(FT[k][7]));
    if (FT[k][8] != 0 && (FT[k][0] & 'h80) != 0)
      chk("rises at stop", 32'(p_rise - r0), 32'(FT[k][8]));
    if (FT[k][8] != 0 && (FT[k][0] & 'h80) == 0)
      chk("falls at stop", 32'(p_fall - f0), 32'(FT[k][8]));
    if (FT[k][9] != 2)
      chk("uart low", 32'(lo_pre != l0), 32'(FT[k][9]));
    if (k == 0)
    begin
      bus_rd(lbs_pkg::IDX_STATUS, v);
      chk("status flags", v & 32'h2f, 32'h27);
    end
    // bus has long returned high before the gate is dropped
    bus_wr(lbs_pkg::IDX_CTRL0, 32'h0);
  endtask : run_frame

  // main sequence
  initial
  begin
    rst_in = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = '0;
    wdat = '0;
    uart_tx = 1'b1;
    gpio_tx = 1'b1;
    go = 1'b0;
    brk = '0;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    bus_rd(lbs_pkg::IDX_CTRL0, v);
    chk("ctrl0 reset", v, 32'h0);
    bus_rd(lbs_pkg::IDX_STATUS, v);
    chk("reset done", v & 32'h20, 32'h20);
    bus_rd(3'h6, v);
    chk("unmapped", v, 32'h0);
    bus_wr(lbs_pkg::IDX_CTRL0, 32'hfffe);
    bus_rd(lbs_pkg::IDX_CTRL0, v);
    chk("ctrl0 mask", v, 32'h0f9e);
    bus_wr(lbs_pkg::IDX_EDGE_CFG, 32'h62);
    bus_wr(lbs_pkg::IDX_CTRL0, 32'h1);
    t0 = cyc;
    bus_rd(lbs_pkg::IDX_CTRL0, v);
    chk("ctrl0 soft reset", v, 32'h1);
    bus_rd(lbs_pkg::IDX_STATUS, v);
    chk("reset busy", v & 32'h20, 32'h0);
    bus_wr(lbs_pkg::IDX_EDGE_CFG, 32'h55);
    while ((v & 32'h20) == 0) bus_rd(lbs_pkg::IDX_STATUS, v);
    chk("reset length", 32'(cyc - t0 >= 1870 && cyc - t0 <= 1885), 1);
    bus_rd(lbs_pkg::IDX_CTRL0, v);
    chk("ctrl0 cleared", v, 32'h0);
    bus_rd(lbs_pkg::IDX_EDGE_CFG, v);
    chk("cfg cleared", v, 32'h0);
    // normal mode, then gpio pins take over the transceiver
    uart_tx <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk("lin tx uart", 32'(lin_tx), 32'h0);
    chk("gpio rx normal", 32'(gpio_rx), 32'h1);
    bus_wr(lbs_pkg::IDX_CTRL0, 32'h200);
    repeat (6) @(posedge clk_in);
    chk("lin tx gpio high", 32'(lin_tx), 32'h1);
    gpio_tx <= 1'b0;
    // two sync flops each way plus the output registers
    repeat (8) @(posedge clk_in);
    chk("lin tx gpio low", 32'(lin_tx), 32'h0);
    chk("gpio rx test", 32'(gpio_rx), 32'h0);
    chk("uart rx test", 32'(uart_rx), 32'h1);
    gpio_tx <= 1'b1;
    uart_tx <= 1'b1;
    bus_wr(lbs_pkg::IDX_CTRL0, 32'h0);
    repeat (6) @(posedge clk_in);
    for (int k = 0; k < 6; k++) run_frame(k);
    // frames are far too short to saturate the break timer
    chk("brk err count", 32'(n_err), 32'h0);
    complete_run();
  end
endmodule : testbench
